// ==== dsf_pkg.sv ====
package dsf_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] DSF_ADDR_STATE_FLAGS = 12'h004;  // display_state_flags
    localparam logic [11:0] DSF_ADDR_CONTROL     = 12'h000;  // local control word
    localparam logic [31:0] DSF_UNMAPPED_DATA    = 32'h0000_0000;

    // ------------------------------------------------------------
    // field positions of display_state_flags
    // ------------------------------------------------------------
    localparam int DSF_POS_PEND_LO   = 24;
    localparam int DSF_POS_ISSUE_LO  = 16;
    localparam int DSF_POS_BLANK_IRQ = 12;
    localparam int DSF_POS_BLANK_WAIT = 11;
    localparam int DSF_POS_BLANK_EFF = 8;
    localparam int DSF_POS_HBLANK    = 7;
    localparam int DSF_POS_VBLANK    = 6;
    localparam int DSF_POS_SWITCH    = 5;
    localparam int DSF_POS_QFULL     = 4;
    localparam int DSF_POS_FETCH_ERR = 3;
    localparam int DSF_POS_OVERFLOW  = 2;
    localparam int DSF_POS_STARVED   = 1;
    localparam int DSF_POS_RUNNING   = 0;

    // ------------------------------------------------------------
    // field positions of local control word
    // ------------------------------------------------------------
    localparam int DSF_POS_CTL_ENABLE = 0;
    localparam int DSF_POS_CTL_BLANK  = 8;
    localparam int DSF_POS_CTL_LIMIT  = 24;

    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [2:0] DSF_PEND_ZERO      = 3'h0;
    localparam logic [2:0] DSF_PEND_ONE       = 3'h1;
    localparam logic [2:0] DSF_LIMIT_RESET    = 3'h1;
    localparam logic       DSF_BLANK_RESET    = 1'b1;
    // arbitrary neutral value, not tied to any part
    localparam logic [7:0] DSF_ISSUE_LEVEL    = 8'hA5;

    // write-one-clear event flags
    typedef struct packed {
        logic blank_done;
        logic line_blank;
        logic frame_blank;
        logic buf_switch;
        logic fetch_err;
        logic overflow;
        logic starved;
    } dsf_events_t;

    // controller-side event strobes and levels
    typedef struct packed {
        logic ptr_write;     // frame pointer register written
        logic new_frame;     // dma starts a new frame buffer
        logic hblank_start;
        logic vblank_start;
        logic frame_end;     // current frame completes
        logic bus_err;
        logic fifo_wr_full;
        logic fifo_empty_need;
    } dsf_ctl_in_t;

    // run state machine
    typedef enum logic [1:0] {
        DSF_STOPPED  = 2'b00,
        DSF_RUNNING  = 2'b01,
        DSF_STOPPING = 2'b10
    } dsf_run_t;

endpackage : dsf_pkg

// ==== dsf_w1c_flag.sv ====
module dsf_w1c_flag
    import dsf_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic set_evt,
    input  wire logic clr_wr,
    output logic      flag
);
    // ------------------------------------------------------------
    // sticky flag
    // ------------------------------------------------------------
    // set beats clear so a colliding event is never dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (clr_wr) begin
            flag <= 1'b0;
        end
    end
endmodule : dsf_w1c_flag

// ==== dsf_pend_counter.sv ====
module dsf_pend_counter
    import dsf_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       running,
    input  wire logic       inc,
    input  wire logic       dec,
    input  wire logic [2:0] limit,
    output logic [2:0]      count
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic room    = count < limit;     // writes beyond limit ignored
    wire logic do_inc  = inc && room;
    wire logic do_dec  = dec && (count != DSF_PEND_ZERO);

    // ------------------------------------------------------------
    // pending pointer count
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            count <= DSF_PEND_ZERO;
        end else if (!running) begin
            count <= DSF_PEND_ZERO;
        end else if (do_inc && !do_dec) begin
            count <= count + DSF_PEND_ONE;
        end else if (do_dec && !do_inc) begin
            count <= count - DSF_PEND_ONE;
        end
    end
endmodule : dsf_pend_counter

// ==== dsf_display_status_flags.sv ====
// Notes on behaviour
// - pointer write counts up, buffer switch down
// - stopped controller zeroes pending count
// - fixed read-only issue level byte
// - blank change sets waiting, applied/stop clears
// - applied while waiting sets blank done
// - blank in effect follows applied request
// - line blank start sets sticky flag
// - frame blank start sets sticky flag
// - queue full falling sets switch flag
// - queue full at limit, cleared on switch
// - stopped controller forces queue full low
// - bus master error sets fetch error
// - fifo write when full sets overflow
// - fifo empty when needed sets starved
// - running indicator shows true run state
// - blank change applied at frame end or stopped
// - disable finishes frame before stopping
module dsf_display_status_flags
    import dsf_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    // avalon-mm slave
    input  wire logic [11:0]  avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    input  wire logic [3:0]   avs_byteenable,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    // controller events
    input  wire dsf_pkg::dsf_ctl_in_t ctl_in,
    // state toward the controller
    output logic              running_indicator,
    output logic              blank_in_effect,
    output logic              fetch_halt
);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one-wait-state slave: waitrequest drops the cycle after a request
    // every transfer costs two cycles; the status word is cheap to
    // build, so the extra cycle buys a registered readdata path and
    // keeps the bus timing independent of the flag logic
    logic       ack;                                     // answer phase
    wire logic  req      = (avs_read || avs_write) && !ack;
    wire logic  hit_flags = avs_address == DSF_ADDR_STATE_FLAGS;
    wire logic  hit_ctl   = avs_address == DSF_ADDR_CONTROL;
    // a write acts at the edge where waitrequest is seen low
    wire logic  wr_take  = avs_write && ack;             // takes effect at done edge
    wire logic  wr_flags = wr_take && hit_flags;
    wire logic  wr_ctl   = wr_take && hit_ctl;
    wire logic [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // byte lanes mask control writes and flag clears alike
    wire logic [31:0] clr_bits = wr_flags ? (avs_writedata & wmask) : 32'h0000_0000;

    // ------------------------------------------------------------
    // control word (software steered)
    // ------------------------------------------------------------
    logic       ctl_enable;                              // subsystem enable
    logic       ctl_blank;                               // force blank request
    logic [2:0] ctl_limit;                               // pointer queue limit
    // read-back image of the control word, reserved bits zero
    wire logic [31:0] ctl_word = {5'h00, ctl_limit, 15'h0000, ctl_blank, 7'h00, ctl_enable};
    wire logic [31:0] ctl_next = (ctl_word & ~wmask) | (avs_writedata & wmask);

    // the limit should only move while stopped or with an empty
    // queue; nothing here enforces that, a limit above four simply
    // lets the count run further than the queue behind it can hold
    // enable resets low, blank request resets high
    // control register, byte lanes honoured
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctl_enable <= 1'b0;
            ctl_blank  <= DSF_BLANK_RESET;
            ctl_limit  <= DSF_LIMIT_RESET;
        end else if (wr_ctl) begin
            ctl_enable <= ctl_next[DSF_POS_CTL_ENABLE];
            ctl_blank  <= ctl_next[DSF_POS_CTL_BLANK];
            ctl_limit  <= ctl_next[DSF_POS_CTL_LIMIT +: 3]; // software keeps it <= 4
        end
    end

    // ------------------------------------------------------------
    // run state machine
    // ------------------------------------------------------------
    // stopped, running and stopping are the only legal codes
    dsf_run_t   run_state;
    dsf_run_t   next_run_state;
    wire logic  running = run_state != DSF_STOPPED;      // stopping still runs
    wire logic  ctl_frame_done = ctl_in.frame_end;       // frame in progress done

    // stopping keeps the controller running until the frame in
    // progress has been fetched, so the pointer queue and the blank
    // logic still see a live display for that last frame
    // disable waits for the frame end before stopping
    always_comb begin
        next_run_state = run_state;
        unique case (run_state)
            DSF_STOPPED:  if (ctl_enable) next_run_state = DSF_RUNNING;
            DSF_RUNNING:  if (!ctl_enable) next_run_state = DSF_STOPPING;
            DSF_STOPPING: if (ctl_frame_done) next_run_state = DSF_STOPPED;
            default:      next_run_state = DSF_STOPPED;
        endcase
    end

    // illegal codes fall back to stopped through the default branch
    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            run_state <= DSF_STOPPED;
        end else begin
            run_state <= next_run_state;
        end
    end

    // ------------------------------------------------------------
    // pending pointer count and queue full
    // ------------------------------------------------------------
    logic [2:0] pend_count;                              // pending_pointer_count
    logic       qfull;                                   // pointer queue full

    // the counter ignores pointer writes once the limit is reached and
    // never wraps below zero on a stray new frame
    dsf_pend_counter u_pend (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .running (running),
        .inc     (ctl_in.ptr_write),
        .dec     (ctl_in.new_frame),
        .limit   (ctl_limit),
        .count   (pend_count)
    );

    // the switch event is only raised from a full queue: a new frame
    // with spare room frees an entry but is not worth a flag
    // limitation: full is seen one cycle after the count reaches the
    // limit, so a read in that cycle can show the count without full
    // set when count reaches the limit; a new frame clears it
    wire logic qfull_fall = qfull && ctl_in.new_frame && running;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            qfull <= 1'b0;
        end else if (!running) begin
            qfull <= 1'b0;
        end else if (ctl_in.new_frame) begin
            qfull <= 1'b0;
        end else if (pend_count >= ctl_limit) begin
            qfull <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // forced blanking tracking
    // ------------------------------------------------------------
    logic       blank_wait;                              // blank change waiting
    logic       blank_req_q;                             // last seen request
    // blank_in_effect resets to one so the display starts dark
    // stopped display applies at once, else only at frame end
    wire logic  blank_apply = (ctl_blank != blank_in_effect)
                              && (!running || ctl_in.frame_end);
    wire logic  blank_change = ctl_blank != blank_req_q;
    wire logic  blank_done_set = blank_apply && blank_wait;

    // the request may toggle many times within a frame; only the
    // value present at the frame end is applied
    // blank in effect follows the request at the allowed moment
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            blank_in_effect <= DSF_BLANK_RESET;
            blank_req_q     <= DSF_BLANK_RESET;
        end else begin
            blank_req_q <= ctl_blank;
            if (blank_apply) begin
                blank_in_effect <= ctl_blank;
            end
        end
    end

    // waiting bit: applying or a stopped controller clears it before a change can
    // set it; the change is seen one cycle late through blank_req_q,
    // so a request applied at once (stopped display) never waits and
    // raises no blank done flag
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            blank_wait <= 1'b0;
        end else if (blank_apply || !running) begin
            blank_wait <= 1'b0;
        end else if (blank_change) begin
            blank_wait <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // sticky event flags
    // ------------------------------------------------------------
    // one bit per flag, same order in set, clear and flag vectors
    dsf_events_t ev_set;
    dsf_events_t ev_clr;
    dsf_events_t ev_flag;

    assign ev_set.blank_done  = blank_done_set;
    assign ev_set.line_blank  = ctl_in.hblank_start;
    assign ev_set.frame_blank = ctl_in.vblank_start;
    assign ev_set.buf_switch  = qfull_fall;
    assign ev_set.fetch_err   = ctl_in.bus_err;
    assign ev_set.overflow    = ctl_in.fifo_wr_full;
    assign ev_set.starved     = ctl_in.fifo_empty_need;

    assign ev_clr.blank_done  = clr_bits[DSF_POS_BLANK_IRQ];
    assign ev_clr.line_blank  = clr_bits[DSF_POS_HBLANK];
    assign ev_clr.frame_blank = clr_bits[DSF_POS_VBLANK];
    assign ev_clr.buf_switch  = clr_bits[DSF_POS_SWITCH];
    assign ev_clr.fetch_err   = clr_bits[DSF_POS_FETCH_ERR];
    assign ev_clr.overflow    = clr_bits[DSF_POS_OVERFLOW];
    assign ev_clr.starved     = clr_bits[DSF_POS_STARVED];

    // clears come only from a status write whose data bit and byte
    // lane are both one; writing zero never touches a flag
    // one write-one-clear cell per event
    for (genvar i = 0; i < $bits(dsf_events_t); i++) begin : g_flag
        dsf_w1c_flag u_flag (
            .sys_clk (sys_clk),
            .rst_b   (rst_b),
            .set_evt (ev_set[i]),
            .clr_wr  (ev_clr[i]),
            .flag    (ev_flag[i])
        );
    end

    // ------------------------------------------------------------
    // status word assembly
    // ------------------------------------------------------------
    // unused positions stay zero; writes to them go nowhere
    // the issue level is a constant byte, so no write path reaches it
    // the count and the full bit are forced to zero one cycle after
    // the controller stops
    // running bit mirrors the registered indicator, not the state
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[DSF_POS_PEND_LO +: 3]  = pend_count;
        status_word[DSF_POS_ISSUE_LO +: 8] = DSF_ISSUE_LEVEL;
        status_word[DSF_POS_BLANK_IRQ]     = ev_flag.blank_done;
        status_word[DSF_POS_BLANK_WAIT]    = blank_wait;
        status_word[DSF_POS_BLANK_EFF]     = blank_in_effect;
        status_word[DSF_POS_HBLANK]        = ev_flag.line_blank;
        status_word[DSF_POS_VBLANK]        = ev_flag.frame_blank;
        status_word[DSF_POS_SWITCH]        = ev_flag.buf_switch;
        status_word[DSF_POS_QFULL]         = qfull;
        status_word[DSF_POS_FETCH_ERR]     = ev_flag.fetch_err;
        status_word[DSF_POS_OVERFLOW]      = ev_flag.overflow;
        status_word[DSF_POS_STARVED]       = ev_flag.starved;
        status_word[DSF_POS_RUNNING]       = running_indicator;
    end

    // unmapped addresses read as zero and swallow writes
    wire logic [31:0] read_mux = hit_flags ? status_word :
                                 hit_ctl   ? ctl_word    : DSF_UNMAPPED_DATA;

    // ------------------------------------------------------------
    // bus answer and registered outputs
    // ------------------------------------------------------------
    // waitrequest idles high; it drops for exactly the answer cycle
    // ack blocks a second take of the same request; a master that
    // holds read or write past the answer edge starts a new transfer
    // readdata holds its value until the next read so a slow master
    // can still pick it up after the answer edge
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ack             <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            ack             <= req;
            avs_waitrequest <= !req;
            if (req && avs_read) begin
                avs_readdata <= read_mux;
            end
        end
    end

    // run indicator and master halt
    // the indicator is taken from the next state so it matches the
    // state register cycle for cycle while still coming from a flop
    // halt stays high while the fetch error flag is set; clearing the
    // flag is the only way to let the bus master continue
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            running_indicator <= 1'b0;
            fetch_halt        <= 1'b0;
        end else begin
            running_indicator <= next_run_state != DSF_STOPPED;
            fetch_halt        <= ev_set.fetch_err || ev_flag.fetch_err;
        end
    end

endmodule : dsf_display_status_flags

// ==== dsf_display_status_flags_assertions.sv ====
module dsf_status_checker
(
    input wire logic                 sys_clk,
    input wire logic                 rst_b,
    input wire logic [11:0]          avs_address,
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic [31:0]          avs_writedata,
    input wire logic [3:0]           avs_byteenable,
    input wire logic [31:0]          avs_readdata,
    input wire logic                 avs_waitrequest,
    input wire dsf_pkg::dsf_ctl_in_t ctl_in,
    input wire logic                 running_indicator,
    input wire logic                 blank_in_effect,
    input wire logic                 fetch_halt
);
    import dsf_pkg::*;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // write-one to the fetch error bit taking effect this edge
    wire logic clr_fetch = avs_write && !avs_waitrequest && avs_byteenable[0]
                           && (avs_address == DSF_ADDR_STATE_FLAGS)
                           && avs_writedata[DSF_POS_FETCH_ERR];
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    // answer edge of a status read
    sequence s_st_rd;
        !avs_waitrequest && $past(avs_read) && ($past(avs_address) == DSF_ADDR_STATE_FLAGS);
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_answer;
        s_req |=> s_ans;
    endproperty
    property p_issue;
        s_st_rd |-> avs_readdata[23:16] == DSF_ISSUE_LEVEL;
    endproperty
    property p_reserved;
        s_st_rd |-> {avs_readdata[31:27], avs_readdata[15:13], avs_readdata[10:9]} == 10'h000;
    endproperty
    property p_pend_stop;
        s_st_rd |-> avs_readdata[0] || (avs_readdata[26:24] == 3'h0);
    endproperty
    property p_qfull_stop;
        s_st_rd |-> !(avs_readdata[DSF_POS_QFULL] && !avs_readdata[DSF_POS_RUNNING]);
    endproperty
    property p_bus_err;
        ctl_in.bus_err |=> fetch_halt;
    endproperty
    property p_fetch_hold;
        fetch_halt && !clr_fetch && !$past(clr_fetch) && !ctl_in.bus_err |=> fetch_halt;
    endproperty
    // blank only moves at frame end or while stopped
    property p_blank_when;
        $changed(blank_in_effect) |-> $past(ctl_in.frame_end) || !$past(running_indicator);
    endproperty
    property p_frame_stop;
        $fell(running_indicator) |-> $past(ctl_in.frame_end) || $past(ctl_in.frame_end, 2);
    endproperty
    a_answer:     assert property (p_answer)     else $error("no single answer cycle");
    a_issue:      assert property (p_issue)      else $error("issue level wrong");
    a_reserved:   assert property (p_reserved)   else $error("reserved bits set");
    a_pend_stop:  assert property (p_pend_stop)  else $error("count while stopped");
    a_qfull_stop: assert property (p_qfull_stop) else $error("full while stopped");
    a_bus_err:    assert property (p_bus_err)    else $error("halt missing");
    a_fetch_hold: assert property (p_fetch_hold) else $error("halt dropped");
    a_blank_when: assert property (p_blank_when) else $error("blank moved early");
    a_frame_stop: assert property (p_frame_stop) else $error("stop before frame end");
endmodule : dsf_status_checker

bind dsf_display_status_flags dsf_status_checker u_chk (.*);

// ==== dsf_display_status_flags_bench.sv ====
module dsf_display_status_flags_bench;
    import dsf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        rst_b, avs_read, avs_write, avs_waitrequest;
    logic        running_indicator, blank_in_effect, fetch_halt;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    dsf_ctl_in_t ctl_in;
    int          miscompares = 0, samples_checked = 0, cycles = 0, n;
    // idle status word: issue level plus blank applied
    localparam logic [31:0] BASE = {8'h00, DSF_ISSUE_LEVEL, 16'h0100};
    localparam logic [11:0] ST   = DSF_ADDR_STATE_FLAGS;
    always #20 sys_clk = ~sys_clk;
    dsf_display_status_flags u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctl_in(ctl_in),
        .running_indicator(running_indicator), .blank_in_effect(blank_in_effect),
        .fetch_halt(fetch_halt));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task conclude();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task rd_chk(input logic [31:0] exp);
        bus(1'b0, ST, 32'h0);
        check(q, exp); // status word compare
    endtask : rd_chk
    task pulse(input dsf_ctl_in_t v);
        @(posedge sys_clk);
        ctl_in <= v;
        @(posedge sys_clk);
        ctl_in <= '0;
    endtask : pulse
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_idle();
        rd_chk(BASE);
        bus(1'b1, ST, 32'hFFFF_FFFF);
        rd_chk(BASE);
        bus(1'b0, 12'h7F0, 32'h0);
        check(q, DSF_UNMAPPED_DATA);
    endtask : t_idle
    task t_flags();
        logic [7:0] ev [5] = '{8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
        int         pos [5] = '{7, 6, 3, 2, 1};
        for (int i = 0; i < 5; i++) begin
            pulse(ev[i]);
            rd_chk(BASE | (32'h1 << pos[i]));
            if (i == 2) begin
                @(negedge sys_clk);
                check({31'h0, fetch_halt}, 32'h1);
            end
            bus(1'b1, ST, ~(32'h1 << pos[i]));
            rd_chk(BASE | (32'h1 << pos[i]));
            bus(1'b1, ST, 32'h1 << pos[i]);
            rd_chk(BASE);
        end
        // line event lands on the same edge as its clearing write
        fork
            bus(1'b1, ST, 32'h80);
            begin
                repeat (2) @(posedge sys_clk);
                ctl_in <= 8'h20;
                @(posedge sys_clk);
                ctl_in <= '0;
            end
        join
        rd_chk(BASE | 32'h80);
        bus(1'b1, ST, 32'h80);
    endtask : t_flags
    task t_queue();
        bus(1'b1, DSF_ADDR_CONTROL, 32'h0200_0101);
        n = 0;
        // start-up latency is the design's own, so poll with a bound
        do begin
            bus(1'b0, ST, 32'h0);
            n++;
        end while (q[0] !== 1'b1 && n < 8);
        check(q, BASE | 32'h1);
        check({31'h0, running_indicator}, 32'h1);
        repeat (3) pulse(8'h80);
        rd_chk(BASE | 32'h0200_0011);
        pulse(8'h40);
        rd_chk(BASE | 32'h0100_0021);
        bus(1'b1, ST, 32'h20);
        pulse(8'h40);
        rd_chk(BASE | 32'h1);
    endtask : t_queue
    task t_blank();
        bus(1'b1, DSF_ADDR_CONTROL, 32'h0200_0001);
        rd_chk(BASE | 32'h0801);
        pulse(8'h08);
        rd_chk((BASE & ~32'h100) | 32'h1001);
        @(negedge sys_clk);
        check({31'h0, blank_in_effect}, 32'h0);
        bus(1'b1, ST, 32'h1000);
        rd_chk((BASE & ~32'h100) | 32'h1);
    endtask : t_blank
    task t_stop();
        repeat (2) pulse(8'h80);
        bus(1'b1, DSF_ADDR_CONTROL, 32'h0200_0000);
        rd_chk((BASE & ~32'h100) | 32'h0200_0011);
        pulse(8'h08);
        rd_chk(BASE & ~32'h100);
        check({31'h0, running_indicator}, 32'h0);
        pulse(8'h80);
        rd_chk(BASE & ~32'h100);
        bus(1'b1, DSF_ADDR_CONTROL, 32'h0200_0100);
        bus(1'b0, ST, 32'h0);
        check(q & 32'h0000_0F01, 32'h0000_0100);
    endtask : t_stop
    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        rst_b          = 1'b0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_address    = 12'h000;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
        ctl_in         = '0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_idle();
        t_flags();
        t_queue();
        t_blank();
        t_stop();
        conclude();
    end
endmodule : dsf_display_status_flags_bench
